// File: shared/sms_defs.svh
// constants of the serial shifter: field positions, reset values, counts
// assumes inclusion from the package and from the design files by bare name
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH

// byte and edge counts
`define SMS_DATA_W      8
`define SMS_EDGES       16
`define SMS_EDGE_W      5

// control register field positions
`define SMS_CR_IE       7
`define SMS_CR_OE       6
`define SMS_CR_IS       5
`define SMS_CR_MASTER_ROLE_BIT     4
`define SMS_CR_CLOCK_IDLE_POLARITY     3
`define SMS_CR_CLOCK_CAPTURE_PHASE     2
`define SMS_CR_RATE_HI  1
`define SMS_CR_RATE_LO  0
`define SMS_CR_RESET    8'h00

// status register field positions
`define SMS_SR_DONE     7
`define SMS_SR_WRITE_COLLISION_FLAG     6
`define SMS_SR_MODE_FAULT_FLAG     4

// internal clock division per rate code
`define SMS_DIV_00      2
`define SMS_DIV_01      4
`define SMS_DIV_10      16
`define SMS_DIV_11      32

// raw pin bit positions inside the synchroniser vector
`define SMS_PIN_SCK     0
`define SMS_PIN_SS      1
`define SMS_PIN_MOSI    2
`define SMS_PIN_MISO    3
`define SMS_PIN_N       4

`endif

// File: shared/sms_pkg.sv
// types of the serial shifter
// assumes sms_defs.svh on the include path
`include "sms_defs.svh"

package sms_pkg;

  // transfer state of the core
  typedef enum logic {
    SMS_ST_IDLE,
    SMS_ST_SHIFT
  } sms_state_type;

  // whole state of the core
  typedef struct packed {
    logic [`SMS_DATA_W-1:0] ctrl;
    logic [`SMS_DATA_W-1:0] shift;
    logic [`SMS_DATA_W-1:0] rxbuf;
    logic [`SMS_EDGE_W-1:0] edges;
    logic                   done;
    logic                   done_seen;
    logic                   write_collision_flag;
    logic                   write_collision_flag_seen;
    logic                   mode_fault_flag;
    logic                   mode_fault_flag_seen;
    sms_state_type          state;
    logic                   sck;
    logic                   sck_prev;
    logic                   rx_bit;
    logic                   irq;
  } sms_core_type;

  // state of the pin synchroniser
  typedef struct packed {
    logic [`SMS_PIN_N-1:0] meta;
    logic [`SMS_PIN_N-1:0] sync;
  } sms_sync_type;

  // state of the rate generator
  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } sms_gen_type;

endpackage : sms_pkg

// File: shared/sms_link_if.sv
// carrier between the core, the pin synchroniser and the rate generator
// assumes all three parties run on the same system clock
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.svh"

interface sms_link_if;
  logic [`SMS_PIN_N-1:0] raw;   // pins as they arrive
  logic [`SMS_PIN_N-1:0] sync;  // pins after two flip-flops
  logic                  run;   // master transfer in progress
  logic [1:0]            rate;  // rate code
  logic                  tick;  // half serial clock period elapsed

  modport sync_side (input raw, output sync);
  modport gen_side  (input run, input rate, output tick);
  modport core_side (output raw, input sync, output run, output rate, input tick);
endinterface : sms_link_if

`default_nettype wire

// File: verilog/sms_pin_sync.sv
// two flip-flop synchroniser for the serial pins
// assumes pins are asynchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.svh"

module sms_pin_sync (
  // clock and reset
  input  wire logic     clk_sys_i,
  input  wire logic     reset_n_i,
  // pins
  sms_link_if.sync_side lk
);
  import sms_pkg::*;

  // select resets to its idle high level so no false selection follows reset
  localparam logic [`SMS_PIN_N-1:0] PIN_RST = {{(`SMS_PIN_N-1){1'b0}}, 1'b1} << `SMS_PIN_SS;

  sms_sync_type s_ff;
  sms_sync_type nxt_s;

  // first stage is read only by the second
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.meta = lk.raw;
    nxt_s.sync = s_ff.meta;
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_ff <= '{meta: PIN_RST, sync: PIN_RST};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lk.sync = s_ff.sync;
endmodule : sms_pin_sync

`default_nettype wire

// File: verilog/sms_rate_gen.sv
// half-period tick generator for the master serial clock
// assumes run stays high for a whole master transfer
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.svh"

module sms_rate_gen #(
  parameter int CNT_W = 5
) (
  // clock and reset
  input  wire logic    clk_sys_i,
  input  wire logic    reset_n_i,
  // rate control and tick
  sms_link_if.gen_side lk
);
  import sms_pkg::*;

  // elaboration check: the half-period counter is five bits wide
  if (CNT_W != 5 || (`SMS_DIV_11 / 2) > 31) begin : g_bad_width
    $error("sms_rate_gen: counter width cannot serve the divider");
  end

  sms_gen_type s_ff;
  sms_gen_type nxt_s;
  logic [4:0]  half_cnt;

  // half period in clocks for each rate code
  always_comb begin
    unique case (lk.rate)
      2'b00: half_cnt = 5'(`SMS_DIV_00 / 2);
      2'b01: half_cnt = 5'(`SMS_DIV_01 / 2);
      2'b10: half_cnt = 5'(`SMS_DIV_10 / 2);
      2'b11: half_cnt = 5'(`SMS_DIV_11 / 2);
    endcase
  end

  // count while running, tick on each half period
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (!lk.run) begin
      nxt_s.cnt = 5'h00;
    end else if (s_ff.cnt == half_cnt - 5'h01) begin
      nxt_s.cnt  = 5'h00;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + 5'h01;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lk.tick = s_ff.tick;
endmodule : sms_rate_gen

`default_nettype wire

// File: verilog/sms_shifter.sv
// full-duplex serial shifter, master or slave, with its software registers
// assumes software strobes are one-cycle pulses on clk_sys_i; pins are async
//
// Behaviour
// - master data write loads shifter, starts, MSB first
// - done sets flag; irq needs source and enable
// - last edge copies shifter to read buffer
// - done clears by status access then data read
// - data writes ignored while done unacknowledged
// - slave uses SCK, ignores rate bits
// - slave receives on MOSI, sends on MISO
// - eight clock pulses, one bit each way
// - polarity sets idle SCK level
// - phase set captures on second edge
// - phase clear captures on first edge
// - low select freezes phase-clear slave data register
// - write during transfer discarded, collision flagged
// - collision flag never raises interrupt
// - phase-set slave drives MISO from first edge
// - phase-clear slave write after select low collides
// - master collision is write while clocking
// - master with select low faults to slave
// - fault clears by status read then control write
// - fault blocks setting output enable and master
// - overrun silent, buffer keeps first byte
// - irq when one flag sets, other clear
// - rate codes divide clock by 2,4,16,32
// - master drives SCK and MOSI, samples MISO
`timescale 1ns/1ps
`default_nettype none
`include "sms_defs.svh"

module sms_shifter (
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  // software data register access
  input  wire logic                   data_wr_i,
  input  wire logic [`SMS_DATA_W-1:0] data_wdata_i,
  input  wire logic                   data_rd_i,
  output logic      [`SMS_DATA_W-1:0] data_rdata_o,
  // software control and status access
  input  wire logic                   ctrl_wr_i,
  input  wire logic [`SMS_DATA_W-1:0] ctrl_wdata_i,
  output logic      [`SMS_DATA_W-1:0] control_register_o,
  input  wire logic                   status_rd_i,
  output logic      [`SMS_DATA_W-1:0] status_register_o,
  output logic                        irq_o,
  // serial pins
  input  wire logic                   sck_i,
  output logic                        sck_o,
  output logic                        sck_oe_o,
  input  wire logic                   ss_n_i,
  input  wire logic                   mosi_i,
  output logic                        mosi_o,
  output logic                        mosi_oe_o,
  input  wire logic                   miso_i,
  output logic                        miso_o,
  output logic                        miso_oe_o
);
  import sms_pkg::*;

  sms_link_if lk ();

  sms_core_type s_ff;
  sms_core_type nxt_s;

  logic                   master;
  logic                   clock_capture_phase;
  logic                   sck_s;
  logic                   ss_n_s;
  logic                   din;
  logic                   busy;
  logic                   edge_ev;
  logic                   done_set;
  logic                   wr_blocked;
  logic [`SMS_EDGE_W-1:0] e_cnt;
  logic [`SMS_DATA_W-1:0] cr_val;

  // pins into the synchroniser, rate and run out to the generator
  assign lk.raw[`SMS_PIN_SCK]  = sck_i;
  assign lk.raw[`SMS_PIN_SS]   = ss_n_i;
  assign lk.raw[`SMS_PIN_MOSI] = mosi_i;
  assign lk.raw[`SMS_PIN_MISO] = miso_i;
  assign lk.rate = {s_ff.ctrl[`SMS_CR_RATE_HI], s_ff.ctrl[`SMS_CR_RATE_LO]};
  assign lk.run  = master && (s_ff.state == SMS_ST_SHIFT);

  sms_pin_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .lk        (lk)
  );

  sms_rate_gen #(
    .CNT_W (5)
  ) u_gen (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .lk        (lk)
  );

  // role and synchronised pins
  assign master = s_ff.ctrl[`SMS_CR_MASTER_ROLE_BIT];
  assign clock_capture_phase   = s_ff.ctrl[`SMS_CR_CLOCK_CAPTURE_PHASE];
  assign sck_s  = lk.sync[`SMS_PIN_SCK];
  assign ss_n_s = lk.sync[`SMS_PIN_SS];
  assign din    = master ? lk.sync[`SMS_PIN_MISO] : lk.sync[`SMS_PIN_MOSI];

  // busy marks when a data write collides
  assign busy = (s_ff.state == SMS_ST_SHIFT)
             || (!master && !ss_n_s && !clock_capture_phase);
  assign wr_blocked = s_ff.done && !s_ff.done_seen;

  // serial clock edge: generator tick as master, pin edge as selected slave
  assign edge_ev = master ? (s_ff.state == SMS_ST_SHIFT && lk.tick)
                          : (!ss_n_s && sck_s != s_ff.sck_prev);
  assign e_cnt   = s_ff.edges + 5'h01;
  assign done_set = edge_ev && (e_cnt == 5'(`SMS_EDGES));

  // next state
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.sck_prev = sck_s;
    cr_val         = ctrl_wdata_i;

    // software side first so that hardware events win below
    if (status_rd_i) begin
      if (s_ff.done) nxt_s.done_seen = 1'b1;
      if (s_ff.mode_fault_flag) nxt_s.mode_fault_flag_seen = 1'b1;
      if (s_ff.write_collision_flag) nxt_s.write_collision_flag_seen = 1'b1;
    end
    if (data_rd_i && s_ff.done_seen) begin
      nxt_s.done      = 1'b0;
      nxt_s.done_seen = 1'b0;
    end
    if ((data_rd_i || data_wr_i) && s_ff.write_collision_flag_seen) begin
      nxt_s.write_collision_flag      = 1'b0;
      nxt_s.write_collision_flag_seen = 1'b0;
    end
    if (data_wr_i && !wr_blocked) begin
      if (busy) begin
        nxt_s.write_collision_flag = 1'b1;
      end else begin
        nxt_s.shift = data_wdata_i;
        if (master) begin
          nxt_s.state = SMS_ST_SHIFT;
          nxt_s.edges = '0;
        end
      end
    end
    if (ctrl_wr_i) begin
      if (s_ff.mode_fault_flag && !s_ff.mode_fault_flag_seen) begin
        cr_val[`SMS_CR_OE]   = ctrl_wdata_i[`SMS_CR_OE] & s_ff.ctrl[`SMS_CR_OE];
        cr_val[`SMS_CR_MASTER_ROLE_BIT] = ctrl_wdata_i[`SMS_CR_MASTER_ROLE_BIT] & s_ff.ctrl[`SMS_CR_MASTER_ROLE_BIT];
      end
      if (s_ff.mode_fault_flag_seen) begin
        nxt_s.mode_fault_flag      = 1'b0;
        nxt_s.mode_fault_flag_seen = 1'b0;
      end
      nxt_s.ctrl = cr_val;
    end

    // serial clock edges: capture on the phase-selected edge, move data on the other,
    // so the far side never sees the data line change under its capture edge;
    // the first edge of phase one only launches the bit already standing
    if (edge_ev) begin
      nxt_s.edges = e_cnt;
      nxt_s.state = SMS_ST_SHIFT;
      if (master) nxt_s.sck = ~s_ff.sck;
      if (e_cnt[0] != clock_capture_phase) begin
        nxt_s.rx_bit = din;
      end else if (e_cnt != 5'h01) begin
        nxt_s.shift = {s_ff.shift[`SMS_DATA_W-2:0], s_ff.rx_bit};
      end
      if (done_set) begin
        nxt_s.state = SMS_ST_IDLE;
        nxt_s.edges = '0;
        nxt_s.done  = 1'b1;
        if (!s_ff.done) begin
          // phase one ends on a capture edge, so its last bit comes straight from din
          nxt_s.rxbuf = clock_capture_phase ? {s_ff.shift[`SMS_DATA_W-2:0], din} : nxt_s.shift;
          nxt_s.done_seen = 1'b0;
        end
      end
    end

    // a deselected slave abandons a partial byte
    if (!master && ss_n_s) begin
      nxt_s.state = SMS_ST_IDLE;
      nxt_s.edges = '0;
    end

    // idle clock level follows polarity
    if (nxt_s.state == SMS_ST_IDLE) begin
      nxt_s.sck = s_ff.ctrl[`SMS_CR_CLOCK_IDLE_POLARITY];
    end

    // master with select low: fault, fall back to slave
    if (master && !ss_n_s) begin
      nxt_s.mode_fault_flag              = 1'b1;
      nxt_s.mode_fault_flag_seen         = 1'b0;
      nxt_s.ctrl[`SMS_CR_OE]   = 1'b0;
      nxt_s.ctrl[`SMS_CR_MASTER_ROLE_BIT] = 1'b0;
      nxt_s.state             = SMS_ST_IDLE;
      nxt_s.edges             = '0;
    end

    // one source request when exactly one flag stands
    nxt_s.irq = nxt_s.ctrl[`SMS_CR_IE] && nxt_s.ctrl[`SMS_CR_IS]
             && (nxt_s.done ^ nxt_s.mode_fault_flag);
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // software view
  assign data_rdata_o       = s_ff.rxbuf;
  assign control_register_o = s_ff.ctrl;
  assign status_register_o  = {s_ff.done, s_ff.write_collision_flag, 1'b0, s_ff.mode_fault_flag, 4'h0};
  assign irq_o              = s_ff.irq;

  // pins: master drives clock and MOSI, selected slave drives MISO
  assign sck_o     = s_ff.sck;
  assign sck_oe_o  = master && s_ff.ctrl[`SMS_CR_OE];
  assign mosi_o    = s_ff.shift[`SMS_DATA_W-1];
  assign mosi_oe_o = master && s_ff.ctrl[`SMS_CR_OE];
  assign miso_o    = s_ff.shift[`SMS_DATA_W-1];
  assign miso_oe_o = !master && s_ff.ctrl[`SMS_CR_OE] && !ss_n_s
                  && (!clock_capture_phase || s_ff.state == SMS_ST_SHIFT);

  // interrupt only with source and enable
  chk_irq_gated: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    irq_o |-> s_ff.ctrl[`SMS_CR_IE] && s_ff.ctrl[`SMS_CR_IS])
    else $error("irq without enable and source select");

  // collision flag alone never interrupts
  chk_write_collision_flag_quiet: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_ff.write_collision_flag && !s_ff.done && !s_ff.mode_fault_flag |-> !irq_o)
    else $error("collision flag raised an interrupt");

  // master write accepted starts a transfer with the byte
  chk_master_load: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    data_wr_i && master && !busy && !wr_blocked && ss_n_s
    |=> s_ff.state == SMS_ST_SHIFT && s_ff.shift == $past(data_wdata_i))
    else $error("master write did not start a transfer");

  // buffer copy marks exactly sixteen edges
  chk_eight_pulses: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $rose(s_ff.done) |-> $past(s_ff.edges) == 5'(`SMS_EDGES - 1))
    else $error("done raised at the wrong edge count");

  // done never clears without acknowledge
  chk_done_holds: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_ff.done && !s_ff.done_seen && !status_rd_i |=> s_ff.done)
    else $error("done cleared without status access");

  // ignored write leaves the shifter alone
  chk_write_ignored: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    data_wr_i && wr_blocked && master && s_ff.state == SMS_ST_IDLE && ss_n_s
    |=> s_ff.shift == $past(s_ff.shift) && s_ff.state == SMS_ST_IDLE)
    else $error("write accepted while done unacknowledged");

  // write during transfer sets collision
  chk_write_collision_flag_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    data_wr_i && busy && !wr_blocked |=> s_ff.write_collision_flag)
    else $error("collision not flagged");

  // buffer frozen while done stands
  chk_rx_kept: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_ff.done |=> $stable(s_ff.rxbuf))
    else $error("receive buffer overwritten during overrun");

  // mode fault forces slave and disables pins
  chk_mode_fault: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    master && !ss_n_s |=> s_ff.mode_fault_flag && !s_ff.ctrl[`SMS_CR_MASTER_ROLE_BIT] && !s_ff.ctrl[`SMS_CR_OE])
    else $error("mode fault not taken");

  // fault blocks setting master outside clearing sequence
  chk_fault_block: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ctrl_wr_i && s_ff.mode_fault_flag && !s_ff.mode_fault_flag_seen && !s_ff.ctrl[`SMS_CR_MASTER_ROLE_BIT]
    |=> !s_ff.ctrl[`SMS_CR_MASTER_ROLE_BIT] && (!s_ff.ctrl[`SMS_CR_OE] ||
        $past(s_ff.ctrl[`SMS_CR_OE])))
    else $error("master bit set during mode fault");

  // idle clock sits at polarity
  chk_idle_level: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_ff.state == SMS_ST_IDLE && $past(s_ff.state == SMS_ST_IDLE)
    |-> s_ff.sck == $past(s_ff.ctrl[`SMS_CR_CLOCK_IDLE_POLARITY]))
    else $error("idle clock level differs from polarity");

  // slave never sees generator ticks
  chk_slave_no_tick: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!master ##1 !master) |-> !lk.tick)
    else $error("rate generator ran in slave role");

  // phase-set slave stays off MISO before first edge
  chk_miso_wait: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !master && clock_capture_phase && s_ff.state == SMS_ST_IDLE |-> !miso_oe_o)
    else $error("MISO driven before first clock edge");

  // phase-set slave takes MISO at its first clock edge
  chk_miso_first: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !master && clock_capture_phase && s_ff.ctrl[`SMS_CR_OE] && s_ff.state == SMS_ST_IDLE && edge_ev
    |=> miso_oe_o || ss_n_s || master || !clock_capture_phase || !s_ff.ctrl[`SMS_CR_OE])
    else $error("MISO not driven after first clock edge");
endmodule : sms_shifter

`default_nettype wire

// File: test/sms_spi_peer.sv
// far-side serial party: slave to a master shifter, master to a slave one
// assumes the bench resolves every wire from both parties' enables
`timescale 1ns/1ps
`default_nettype none

module sms_spi_peer (
  // clock and resolved wires
  input  wire logic clk_i,
  input  wire logic sck_w_i,
  input  wire logic mosi_w_i,
  input  wire logic miso_w_i,
  // peer drive
  output logic      sck_o,
  output logic      ss_n_o,
  output logic      mosi_o,
  output logic      miso_o
);
  logic [7:0] rx;
  int         edges;

  // idle levels: deselected, clock low
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
    miso_o = 1'b0;
  end

  // count every serial clock transition on the wire
  always @(sck_w_i) edges++;

  // select level and clock idle level, changed only between frames
  task automatic set_ss(input logic v, input logic clock_idle_polarity);
    sck_o = clock_idle_polarity;
    ss_n_o = v;
  endtask : set_ss

  // answer a master: launch on one edge, capture on the other
  task automatic serve(input logic [7:0] tx, input logic clock_capture_phase);
    rx = 8'h00;
    if (!clock_capture_phase) begin
      miso_o = tx[7];
      tx = tx << 1;
    end
    for (int e = 1; e <= 16; e++) begin
      @(sck_w_i);
      if (e[0] != clock_capture_phase) begin
        rx = {rx[6:0], mosi_w_i};
      end else begin
        miso_o = tx[7];
        tx = tx << 1;
      end
    end
    miso_o = ~miso_o; // released line, no pull
  endtask : serve

  // act as master: sixteen edges, six clocks per half period
  task automatic drive(input logic [7:0] tx, input logic clock_capture_phase);
    rx = 8'h00;
    if (!clock_capture_phase) begin
      mosi_o = tx[7];
      tx = tx << 1;
    end
    for (int e = 1; e <= 16; e++) begin
      repeat (6) @(posedge clk_i);
      #1 sck_o = ~sck_o;
      if (e[0] != clock_capture_phase) begin
        rx = {rx[6:0], miso_w_i};
      end else begin
        mosi_o = tx[7];
        tx = tx << 1;
      end
    end
    repeat (6) @(posedge clk_i);
    #1 mosi_o = ~mosi_o; // released line, no pull
  endtask : drive
endmodule : sms_spi_peer

`default_nettype wire

// File: test/sms_shifter_tb.sv
// self-checking bench of the serial shifter with a far-side peer model
// assumes the shifter and peer compile before this file
`timescale 1ns/1ps
`default_nettype none

module sms_shifter_tb;
  logic       clk_sys, reset_n, dwr, drd, cwr, srd, irq;
  logic [7:0] wdata, rdata, ctrl, stat;
  logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic       p_sck, p_ss_n, p_mosi, p_miso, sck_w, mosi_w, miso_w;
  int         fail_count = 0;
  int         checked = 0;

  // wire levels from both parties' enables
  assign sck_w  = sck_oe ? sck_o : p_sck;
  assign mosi_w = mosi_oe ? mosi_o : p_mosi;
  assign miso_w = miso_oe ? miso_o : p_miso;

  sms_shifter sms_shifter_i (.clk_sys_i(clk_sys), .reset_n_i(reset_n), .data_wr_i(dwr),
    .data_wdata_i(wdata), .data_rd_i(drd), .data_rdata_o(rdata), .ctrl_wr_i(cwr),
    .ctrl_wdata_i(wdata), .control_register_o(ctrl), .status_rd_i(srd),
    .status_register_o(stat), .irq_o(irq), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_o(sck_oe), .ss_n_i(p_ss_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe));

  sms_spi_peer sms_spi_peer_i (.clk_i(clk_sys), .sck_w_i(sck_w), .mosi_w_i(mosi_w),
    .miso_w_i(miso_w), .sck_o(p_sck), .ss_n_o(p_ss_n), .mosi_o(p_mosi), .miso_o(p_miso));

  // 10 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // comparison with counting
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // verdict and end of run
  task automatic final_report;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // one strobe: 0 data write, 1 control write, 2 data read, 3 status read
  task automatic sw(input int k, input logic [7:0] v);
    @(posedge clk_sys) #1;
    {srd, drd, cwr, dwr} = 4'(1 << k);
    wdata = v;
    @(posedge clk_sys) #1;
    {srd, drd, cwr, dwr} = 4'h0;
    @(posedge clk_sys) #1;
  endtask : sw

  // bounded wait for the done flag, counting clocks
  task automatic wait_done(output int n);
    n = 0;
    while (stat[7] !== 1'b1 && n < 2000) begin
      @(posedge clk_sys) #1;
      n++;
    end
    chk("done", 8'(stat[7]), 8'h01);
  endtask : wait_done

  // one master byte against the peer, then the clearing sequence
  task automatic mbyte(input logic [7:0] c, tx, px, input int half);
    int n;
    sw(1, c);
    chk("sck idle", 8'(sck_o), 8'(c[3]));
    chk("pins on", 8'({sck_oe, mosi_oe, miso_oe}), 8'h06);
    sms_spi_peer_i.edges = 0;
    fork
      sms_spi_peer_i.serve(px, c[2]);
      begin
        sw(0, tx);
        wait_done(n);
      end
    join
    chk("rate", 8'(n >= 16 * half - 2 && n <= 16 * half + 4), 8'h01);
    chk("edges", 8'(sms_spi_peer_i.edges), 8'd16);
    chk("sck idle end", 8'(sck_o), 8'(c[3]));
    chk("irq", 8'(irq), 8'(c[5]));
    chk("peer rx", sms_spi_peer_i.rx, tx);
    sw(3, 8'h00);
    sw(2, 8'h00);
    if (half > 4) chk("rx buffer", rdata, px);
    chk("status clear", stat, 8'h00);
  endtask : mbyte

  // watchdog
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end

  // main sequence
  initial begin
    int n;
    {reset_n, dwr, drd, cwr, srd, wdata} = '0;
    repeat (20) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    chk("reset status", stat, 8'h00);
    // master in the four modes at rate 16, then the other three rate codes
    for (int i = 0; i < 4; i++) begin
      mbyte(8'hd2 | 8'(i << 2) | ((i == 1) ? 8'h00 : 8'h20), 8'ha5 ^ 8'(i), 8'h3c + 8'(i), 8);
    end
    mbyte(8'hf0, 8'h81, 8'h18, 1);
    mbyte(8'hf1, 8'h81, 8'h18, 2);
    mbyte(8'hf3, 8'h42, 8'he7, 16);
    // collision mid-transfer, then a write while done is pending
    sw(1, 8'hf2);
    fork
      sms_spi_peer_i.serve(8'h69, 1'b0);
      begin
        sw(0, 8'h96);
        repeat (20) @(posedge clk_sys) #1;
        sw(0, 8'h11);
        chk("write_collision_flag", stat, 8'h40);
        chk("write_collision_flag irq", 8'(irq), 8'h00);
        wait_done(n);
      end
    join
    chk("unaffected", sms_spi_peer_i.rx, 8'h96);
    sms_spi_peer_i.edges = 0;
    sw(0, 8'h77);
    repeat (40) @(posedge clk_sys) #1;
    chk("write ignored", 8'(sms_spi_peer_i.edges), 8'h00);
    chk("flags", stat, 8'hc0);
    sw(3, 8'h00);
    sw(2, 8'h00);
    chk("buffer", rdata, 8'h69);
    chk("flags clear", stat, 8'h00);
    // slave in the four modes, rate bits set but unused
    for (int i = 0; i < 4; i++) begin
      sw(1, 8'h43 | 8'(i << 2));
      sms_spi_peer_i.set_ss(1'b1, i[1]);
      sw(0, 8'hc3 ^ 8'(i));
      sms_spi_peer_i.set_ss(1'b0, i[1]);
      repeat (4) @(posedge clk_sys) #1;
      chk("miso oe", 8'(miso_oe), 8'(!i[0]));
      if (!i[0]) begin
        sw(0, 8'hee);
        chk("slave write_collision_flag", stat, 8'h40);
      end
      sms_spi_peer_i.drive(8'h5a + 8'(i), i[0]);
      chk("slave tx", sms_spi_peer_i.rx, 8'hc3 ^ 8'(i));
      if (i == 3) sms_spi_peer_i.drive(8'h99, 1'b1);
      chk("slave done", stat, 8'h80 | (i[0] ? 8'h00 : 8'h40));
      sms_spi_peer_i.set_ss(1'b1, i[1]);
      sw(3, 8'h00);
      sw(2, 8'h00);
      chk("slave rx", rdata, 8'h5a + 8'(i));
    end
    // mode fault and its clearing sequence
    sw(1, 8'hf0);
    sms_spi_peer_i.set_ss(1'b0, 1'b0);
    repeat (4) @(posedge clk_sys) #1;
    chk("fault flag", stat, 8'h10);
    chk("fault ctrl", ctrl, 8'ha0);
    chk("fault pins", 8'({sck_oe, mosi_oe, miso_oe}), 8'h00);
    chk("fault irq", 8'(irq), 8'h01);
    sms_spi_peer_i.set_ss(1'b1, 1'b0);
    repeat (4) @(posedge clk_sys) #1;
    sw(1, 8'hf0);
    chk("blocked", ctrl, 8'ha0);
    sw(3, 8'h00);
    sw(1, 8'hf0);
    chk("fault clear", stat, 8'h00);
    chk("restored", ctrl, 8'hf0);
    final_report();
  end
endmodule : sms_shifter_tb

`default_nettype wire
